// *** core/iosf_core.sv ***
// Fallback, pulse counter and offset logic of an I/O slave
`timescale 1ns/10ps
// Contract
// [R1] Hold set: setpoint keeps last value on loss
// [R2] Hold clear: setpoint takes fallback on loss
// [R3] Per-channel fallback value, default 0
// [R4] Loss declared after delay of 0.28 s steps; code declares it only after delay+1 steps
// [R5] Clear-after-read zeroes counter after read
// [R6] Clear only when both words polled together
// [R7] Clear disabled: reads never alter counter
// [R8] Capture and clear atomic, no pulse lost
// [R9] Offset-corrected word per input channel
// [R10] Saturation off: result wraps modulo 2^16
// [R11] Saturation on: result floors at zero
// [R12] Saturation setting held per channel
module iosf_core
  import iosf_pkg::*;
#(
  parameter int TICK_CYCLES = STEP_CYCLES,
  parameter int NCH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // Modbus protocol side
  input wire iosf_mb_req_t mb_req,
  output logic [31:0] mb_cnt_data,
  output logic mb_cnt_valid,
  // Field pins and values
  input wire logic [NCH-1:0] pulse_in,
  input wire logic [NCH-1:0][15:0] analog_input_high_word,
  output logic [NCH-1:0][15:0] analog_out_setpoint,
  output logic [NCH-1:0][15:0] offset_corrected_word,
  output logic link_lost
);
  typedef struct packed {
    iosf_bus_t bus;
    logic [31:0] rdata;
    logic [5:0] ctrl;
    logic [7:0] delay;
    logic [NCH-1:0][15:0] fallback_setpoint;
    logic [NCH-1:0][15:0] input_offset_value;
    logic [NEV-1:0] ev;
    logic [NEV-1:0] mask;
    logic [NCH-1:0][15:0] setpoint;
    logic [NCH-1:0][31:0] count;
    logic [NCH-1:0][15:0] corr;
    logic [NCH-1:0] sync1;
    logic [NCH-1:0] sync2;
    logic [NCH-1:0] sync3;
    logic [31:0] presc;
    logic [8:0] elapsed;
    logic lost;
    logic [31:0] cap;
    logic cap_valid;
  } iosf_state_t;

  localparam iosf_state_t ST_RST = '{
    bus: BUS_IDLE, rdata: 32'h0000_0000, ctrl: CTRL_RST, delay: DELAY_RST,
    fallback_setpoint: {NCH{FB_RST}}, input_offset_value: {NCH{OFF_RST}},
    ev: '0, mask: '0, setpoint: '0, count: '0, corr: '0,
    sync1: '0, sync2: '0, sync3: '0, presc: 32'h0000_0000,
    elapsed: 9'h000, lost: 1'b0, cap: 32'h0000_0000, cap_valid: 1'b0};

  iosf_state_t s_q;
  iosf_state_t s_d;
  iosf_avs_req_t avs;
  logic [NCH-1:0][15:0] corr_w;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign avs = '{address: avs_address, read: avs_read, write: avs_write,
                 byteenable: avs_byteenable, writedata: avs_writedata};

  // Offset correction per channel
  for (genvar c = 0; c < NCH; c++) begin : g_off
    iosf_offset u_off (
      .high_word(analog_input_high_word[c]),
      .offset(s_q.input_offset_value[c]),
      .sat_en(s_q.ctrl[CTRL_SAT + c]), // [R12]
      .corrected(corr_w[c])
    );
  end

  always_comb begin
    logic [31:0] rd;
    logic [31:0] wv;
    logic do_wr;
    logic tick;
    logic silent_over;
    logic [NCH-1:0] inc;
    logic [NEV-1:0] ev_set;
    rd = 32'h0000_0000;
    wv = 32'h0000_0000;
    do_wr = 1'b0;
    tick = 1'b0;
    silent_over = 1'b0;
    inc = '0;
    ev_set = '0;
    s_d = s_q;
    s_d.cap_valid = 1'b0;

    // Bus slave: decode on first edge, complete on second
    case (s_q.bus)
      BUS_IDLE: begin
        if (avs.read || avs.write) begin
          s_d.bus = BUS_ACK;
        end
      end
      BUS_ACK: begin
        s_d.bus = BUS_IDLE;
        do_wr = avs.write;
      end
      default: begin
        s_d.bus = BUS_IDLE;
      end
    endcase

    case (avs.address)
      OFS_CTRL: rd = {26'h0, s_q.ctrl};
      OFS_DELAY: rd = {24'h0, s_q.delay};
      OFS_FB0: rd = {16'h0, s_q.fallback_setpoint[0]};
      OFS_FB1: rd = {16'h0, s_q.fallback_setpoint[1]};
      OFS_OFF0: rd = {16'h0, s_q.input_offset_value[0]};
      OFS_OFF1: rd = {16'h0, s_q.input_offset_value[1]};
      OFS_STAT: rd = {31'h0, s_q.lost};
      OFS_IRQ: rd = {28'h0, s_q.ev};
      OFS_MASK: rd = {28'h0, s_q.mask};
      OFS_SP0: rd = {16'h0, s_q.setpoint[0]};
      OFS_SP1: rd = {16'h0, s_q.setpoint[1]};
      OFS_CNT0: rd = s_q.count[0];
      OFS_CNT1: rd = s_q.count[1];
      OFS_COR0: rd = {16'h0, s_q.corr[0]};
      OFS_COR1: rd = {16'h0, s_q.corr[1]};
      default: rd = 32'h0000_0000;
    endcase
    if (s_q.bus == BUS_IDLE) begin
      s_d.rdata = rd;
    end

    wv = be_merge(rd, avs.writedata, avs.byteenable);
    if (do_wr) begin
      case (avs.address)
        OFS_CTRL: s_d.ctrl = wv[5:0];
        OFS_DELAY: s_d.delay = wv[7:0];
        OFS_FB0: s_d.fallback_setpoint[0] = wv[15:0]; // [R3]
        OFS_FB1: s_d.fallback_setpoint[1] = wv[15:0]; // [R3]
        OFS_OFF0: s_d.input_offset_value[0] = wv[15:0];
        OFS_OFF1: s_d.input_offset_value[1] = wv[15:0];
        OFS_MASK: s_d.mask = wv[NEV-1:0];
        default: begin
        end
      endcase
    end

    // Pulse input synchronisers
    s_d.sync1 = pulse_in;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    inc = s_q.sync2 & ~s_q.sync3;

    // Counters with atomic capture and clear
    s_d.cap = s_q.cap;
    for (int c = 0; c < NCH; c++) begin
      s_d.count[c] = s_q.count[c] + {31'h0, inc[c]};
      if (mb_req.cnt_rd && (int'(mb_req.cnt_ch) == c)) begin
        s_d.cap = s_q.count[c];
        s_d.cap_valid = 1'b1;
        if (mb_req.cnt_both && s_q.ctrl[CTRL_CLR + c]) begin // [R6] [R7]
          s_d.count[c] = {31'h0, inc[c]}; // [R5] [R8]
          ev_set[EV_CLR0 + c] = 1'b1;
        end
      end
    end

    // Link-loss timer in steps since last traffic
    if (mb_req.activity || mb_req.wr) begin
      s_d.presc = 32'h0000_0000;
      s_d.elapsed = 9'h000;
    end else begin
      tick = (s_q.presc >= 32'(TICK_CYCLES - 1));
      s_d.presc = tick ? 32'h0000_0000 : s_q.presc + 32'h0000_0001;
      if (tick && (s_q.elapsed != ELAPSED_MAX)) begin
        s_d.elapsed = s_q.elapsed + 9'h001;
      end
    end
    silent_over = (s_q.elapsed > {1'b0, s_q.delay}); // [R4]
    s_d.lost = silent_over && !(mb_req.activity || mb_req.wr);
    if (s_d.lost && !s_q.lost) begin
      ev_set[EV_LOST] = 1'b1;
    end
    if (!s_d.lost && s_q.lost) begin
      ev_set[EV_BACK] = 1'b1;
    end

    // Setpoints: master writes, fallback on loss entry
    for (int c = 0; c < NCH; c++) begin
      if (mb_req.wr && (int'(mb_req.wr_ch) == c)) begin
        s_d.setpoint[c] = mb_req.wr_data;
      end else if (ev_set[EV_LOST] && !s_q.ctrl[CTRL_HOLD + c]) begin
        s_d.setpoint[c] = s_q.fallback_setpoint[c]; // [R2]
      end else begin
        s_d.setpoint[c] = s_q.setpoint[c]; // [R1]
      end
    end

    // Offset-corrected words
    s_d.corr = corr_w; // [R9]

    // Sticky events, write one to clear, set wins
    if (do_wr && (avs.address == OFS_IRQ)) begin
      s_d.ev = s_q.ev & ~wv[NEV-1:0];
    end
    s_d.ev = s_d.ev | ev_set;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = (avs.read || avs.write) && (s_q.bus != BUS_ACK);
  assign avs_readdata = s_q.rdata;
  assign irq = |(s_q.ev & s_q.mask);
  assign mb_cnt_data = s_q.cap;
  assign mb_cnt_valid = s_q.cap_valid;
  assign analog_out_setpoint = s_q.setpoint;
  assign offset_corrected_word = s_q.corr;
  assign link_lost = s_q.lost;
endmodule // iosf_core

// *** core/iosf_pkg.sv ***
// Package for the I/O slave fallback, counter and offset block
package iosf_pkg;
  localparam int CLK_NS = 20;
  localparam longint STEP_NS = 280000000;
  localparam int STEP_CYCLES = int'(STEP_NS / CLK_NS);
  localparam int AW = 6;
  localparam logic [AW-1:0] OFS_CTRL = 6'h00;
  localparam logic [AW-1:0] OFS_DELAY = 6'h04;
  localparam logic [AW-1:0] OFS_FB0 = 6'h08;
  localparam logic [AW-1:0] OFS_FB1 = 6'h0C;
  localparam logic [AW-1:0] OFS_OFF0 = 6'h10;
  localparam logic [AW-1:0] OFS_OFF1 = 6'h14;
  localparam logic [AW-1:0] OFS_STAT = 6'h18;
  localparam logic [AW-1:0] OFS_IRQ = 6'h1C;
  localparam logic [AW-1:0] OFS_MASK = 6'h20;
  localparam logic [AW-1:0] OFS_SP0 = 6'h24;
  localparam logic [AW-1:0] OFS_SP1 = 6'h28;
  localparam logic [AW-1:0] OFS_CNT0 = 6'h2C;
  localparam logic [AW-1:0] OFS_CNT1 = 6'h30;
  localparam logic [AW-1:0] OFS_COR0 = 6'h34;
  localparam logic [AW-1:0] OFS_COR1 = 6'h38;
  // Control field positions
  localparam int CTRL_HOLD = 0;
  localparam int CTRL_CLR = 2;
  localparam int CTRL_SAT = 4;
  localparam logic [5:0] CTRL_RST = 6'h3F;
  localparam logic [7:0] DELAY_RST = 8'h00;
  localparam logic [15:0] FB_RST = 16'h0000;
  localparam logic [15:0] OFF_RST = 16'h0000;
  // Interrupt event bits
  localparam int EV_LOST = 0;
  localparam int EV_BACK = 1;
  localparam int EV_CLR0 = 2;
  localparam int EV_CLR1 = 3;
  localparam int NEV = 4;
  localparam logic [8:0] ELAPSED_MAX = 9'h100;

  typedef struct packed {
    logic activity;
    logic wr;
    logic wr_ch;
    logic [15:0] wr_data;
    logic cnt_rd;
    logic cnt_ch;
    logic cnt_both;
  } iosf_mb_req_t;

  typedef struct packed {
    logic [AW-1:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } iosf_avs_req_t;

  typedef enum logic {BUS_IDLE, BUS_ACK} iosf_bus_t;
endpackage

// *** core/iosf_offset.sv ***
// Offset correction of one analog input high word
`timescale 1ns/10ps
module iosf_offset
  import iosf_pkg::*;
(
  // Operands
  input wire logic [15:0] high_word,
  input wire logic [15:0] offset,
  input wire logic sat_en,
  // Result
  output logic [15:0] corrected
);
  logic [15:0] diff;
  assign diff = high_word - offset; // [R10]
  assign corrected = (sat_en && (offset > high_word)) ? 16'h0000 : diff; // [R11]
endmodule // iosf_offset

// *** verification/iosf_mb_master.sv ***
// Modbus master model driving traffic, setpoint writes and counter polls
`timescale 1ns/10ps
module iosf_mb_master
  import iosf_pkg::*;
(
  // Clock
  input wire logic clk,
  // Requests toward the slave
  output iosf_mb_req_t mb_req
);
  initial begin
    mb_req = '0;
  end
  // One request cycle, then idle
  task automatic send(input logic a, input logic w, input logic c, input logic [15:0] d,
                      input logic rd, input logic b);
    @(posedge clk);
    mb_req <= '{a, w, c, d, rd, c, b};
    @(posedge clk);
    mb_req <= '0;
  endtask
endmodule // iosf_mb_master

// *** verification/iosf_core_chk.sv ***
// Port assertions of the fallback, counter and offset block
`timescale 1ns/10ps
module iosf_core_chk
  import iosf_pkg::*;
#(
  parameter int TICK_CYCLES = 4,
  parameter int NCH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Observed ports
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire iosf_mb_req_t mb_req,
  input wire logic mb_cnt_valid,
  input wire logic [NCH-1:0][15:0] analog_out_setpoint,
  input wire logic link_lost
);
  logic [15:0] quiet_q;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Silent cycles since last traffic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) quiet_q <= 16'h0000;
    else if (mb_req.activity || mb_req.wr) quiet_q <= 16'h0000;
    else if (quiet_q != 16'hFFFF) quiet_q <= quiet_q + 16'h0001;
  end
  wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  poll_valid_a: assert property (mb_req.cnt_rd |=> mb_cnt_valid)
    else $error("poll without capture");
  valid_pulse_a: assert property (!mb_req.cnt_rd |=> !mb_cnt_valid)
    else $error("capture without poll");
  wr_set_a: assert property (mb_req.wr |=>
    analog_out_setpoint[$past(mb_req.wr_ch)] == $past(mb_req.wr_data)) else $error("setpoint");
  act_clr_a: assert property (mb_req.activity || mb_req.wr |=> !link_lost)
    else $error("loss despite traffic");
  hold_lost_a: assert property (link_lost && !mb_req.wr |=> $stable(analog_out_setpoint))
    else $error("setpoint moved while lost");
  lost_early_a: assert property ($rose(link_lost) |-> quiet_q >= TICK_CYCLES)
    else $error("loss declared too early");
  lost_keep_a: assert property (link_lost && !mb_req.activity && !mb_req.wr |=> link_lost)
    else $error("loss dropped in silence");
endmodule // iosf_core_chk

// *** verification/iosf_core_tb.sv ***
// Testbench of the fallback, counter and offset block
`timescale 1ns/10ps
module iosf_core_tb
  import iosf_pkg::*;
();
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq, mb_cnt_valid, link_lost;
  logic [AW-1:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, mb_cnt_data, q;
  iosf_mb_req_t mb_req;
  logic [1:0] pulse_in;
  logic [1:0][15:0] analog_input_high_word, analog_out_setpoint, offset_corrected_word;
  int err_total, compares, n;
  // High word, offset, saturated result, wrapped result
  logic [15:0] rows [4][4] = '{'{16'h1388, 16'h2710, 16'h0000, 16'hEC78},
    '{16'h2328, 16'h03E8, 16'h1F40, 16'h1F40}, '{16'h0000, 16'h0001, 16'h0000, 16'hFFFF},
    '{16'h1234, 16'h1234, 16'h0000, 16'h0000}};
  iosf_core #(.TICK_CYCLES(4), .NCH(2)) iosf_core_inst (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .mb_req(mb_req), .mb_cnt_data(mb_cnt_data), .mb_cnt_valid(mb_cnt_valid),
    .pulse_in(pulse_in), .analog_input_high_word(analog_input_high_word),
    .analog_out_setpoint(analog_out_setpoint), .offset_corrected_word(offset_corrected_word),
    .link_lost(link_lost));
  iosf_mb_master iosf_mb_master_inst (.clk(clk), .mb_req(mb_req));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic stop_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) begin
      err_total++;
      $display("mismatch at %0t: bus request never answered", $time);
    end
    @(posedge clk);
  endtask
  task automatic pulse(input int c);
    @(posedge clk);
    pulse_in[c] <= 1'b1;
    repeat (2) @(posedge clk);
    pulse_in[c] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic poll(input logic b, input logic [31:0] e);
    iosf_mb_master_inst.send(1'b0, 1'b0, 1'b0, 16'h0000, 1'b1, b);
    repeat (2) @(posedge clk);
    chk(mb_cnt_data, e);
  endtask
  task automatic wait_lost();
    n = 0;
    while (link_lost !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
  endtask
  initial begin
    #400000;
    err_total++;
    stop_test();
  end
  initial begin
    {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = '0;
    sys_rst = 1'b1;
    avs_byteenable = 4'hF;
    pulse_in = 2'h0;
    analog_input_high_word = '0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0); chk(q, 32'h3F);
    bus(1'b0, OFS_FB1, 32'h0); chk(q, 32'h0);
    bus(1'b0, 6'h3C, 32'h0); chk(q, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h1F);
    foreach (rows[i]) begin
      analog_input_high_word <= {rows[i][0], rows[i][0]};
      bus(1'b1, OFS_OFF0, {16'h0000, rows[i][1]});
      bus(1'b1, OFS_OFF1, {16'h0000, rows[i][1]});
      repeat (2) @(posedge clk);
      chk({16'h0000, offset_corrected_word[0]}, {16'h0000, rows[i][2]});
      chk({16'h0000, offset_corrected_word[1]}, {16'h0000, rows[i][3]});
      bus(1'b0, OFS_COR1, 32'h0); chk(q, {16'h0000, rows[i][3]});
    end
    repeat (3) pulse(0);
    poll(1'b1, 32'h3);
    poll(1'b1, 32'h0);
    repeat (2) pulse(0);
    poll(1'b0, 32'h2);
    poll(1'b1, 32'h2);
    bus(1'b1, OFS_CTRL, 32'h1B);
    pulse(0);
    poll(1'b1, 32'h1);
    poll(1'b1, 32'h1);
    bus(1'b1, OFS_MASK, 32'h4); chk({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_IRQ, 32'h4); @(posedge clk); chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h3D);
    bus(1'b1, OFS_FB1, 32'hA5A5);
    iosf_mb_master_inst.send(1'b0, 1'b1, 1'b0, 16'h1111, 1'b0, 1'b0);
    iosf_mb_master_inst.send(1'b0, 1'b1, 1'b1, 16'h2222, 1'b0, 1'b0);
    wait_lost();
    chk({31'h0, link_lost}, 32'h1);
    chk({16'h0000, analog_out_setpoint[0]}, 32'h1111);
    chk({16'h0000, analog_out_setpoint[1]}, 32'hA5A5);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_MASK, 32'h1); chk({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_IRQ, 32'h1); @(posedge clk); chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_DELAY, 32'h3);
    iosf_mb_master_inst.send(1'b1, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
    @(posedge clk); chk({31'h0, link_lost}, 32'h0);
    wait_lost();
    chk({31'h0, n >= 15 && n <= 20}, 32'h1);
    stop_test();
  end
endmodule // iosf_core_tb
bind iosf_core iosf_core_chk #(.TICK_CYCLES(TICK_CYCLES), .NCH(NCH)) iosf_core_chk_inst (
  .clk(clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .mb_req(mb_req), .mb_cnt_valid(mb_cnt_valid),
  .analog_out_setpoint(analog_out_setpoint), .link_lost(link_lost));
